// file: pls_pkg.sv
// shared constants and types for the pll lock-status link
package pls_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CL_PERIOD_NS = 800;
  localparam int CL_HALF_CYC = (CL_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 16;
  localparam int FRAME_BITS = 20;
  localparam int DZ_POS = 16;
  localparam int DO_SEL_POS = 18;
  localparam int IF_REQ_POS = 20;
  localparam int LOCK_WIN_CYC = 2;
  localparam int DZ_NARROW_CYC = 1;
  localparam int DZ_WIDE_CYC = 3;
  localparam int READS_VALID = 2;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_SETTLE = 8'h10;
  localparam int ST_BUSY = 0;
  localparam int ST_UNLOCK = 1;
  localparam int ST_VALID = 2;
  localparam int ST_SETTLED = 3;
  localparam int ST_DO = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_UNLOCK = 1;
  localparam logic [31:0] SETTLE_RST = 32'h0000_4E20;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    dz_mode_none_a = 2'b00,
    dz_mode_none_b = 2'b01,
    dz_mode_narrow = 2'b10,
    dz_mode_wide = 2'b11
  } pls_dz_t;
  typedef enum logic [1:0] {
    do_serial = 2'b00,
    do_lock = 2'b01,
    do_if_done = 2'b10,
    do_in_pin = 2'b11
  } pls_do_t;
endpackage : pls_pkg

// file: pls_link_if.sv
// three-wire serial link plus data-out line between controller and synthesizer
`timescale 1ns/1ps
interface pls_link_if;
  logic ce;
  logic cl;
  logic di;
  logic do_line;
  modport device (input ce, input cl, input di, output do_line);
  modport ctrl (output ce, output cl, output di, input do_line);
endinterface : pls_link_if

// file: pls_lock_det.sv
// phase comparator with dead-zone control and per-period unlock detection
`timescale 1ns/1ps
module pls_lock_det import pls_pkg::*; #(
  parameter int WIN = LOCK_WIN_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // edges and mode
  input wire logic fref_edge,
  input wire logic fp_edge,
  input wire pls_dz_t dz_mode,
  // results
  output logic unlock_pulse_q,
  output logic locked_q,
  output logic pump_up_q,
  output logic pump_dn_q
);
  logic up_pend_q, dn_pend_q, bad_q, fp_seen_q, kick_q;
  logic [3:0] w_q;
  wire on_on = (dz_mode == dz_mode_none_a) || (dz_mode == dz_mode_none_b);
  wire [3:0] thr = (dz_mode == dz_mode_wide) ? 4'(DZ_WIDE_CYC) :
                   (dz_mode == dz_mode_narrow) ? 4'(DZ_NARROW_CYC) : 4'h0;
  wire pend = up_pend_q | dn_pend_q;
  wire up_d = fref_edge & ~fp_edge & ~dn_pend_q | up_pend_q & ~fp_edge;
  wire dn_d = fp_edge & ~fref_edge & ~up_pend_q | dn_pend_q & ~fref_edge;
  // phase error past the window marks the period bad
  wire too_wide = pend && (w_q >= 4'(WIN));
  wire period_bad = bad_q | too_wide | ~fp_seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_pend_q <= 1'b0;
      dn_pend_q <= 1'b0;
      w_q <= 4'h0;
      bad_q <= 1'b0;
      fp_seen_q <= 1'b0;
      unlock_pulse_q <= 1'b0;
      locked_q <= 1'b0;
      kick_q <= 1'b0;
      pump_up_q <= 1'b0;
      pump_dn_q <= 1'b0;
    end else begin
      up_pend_q <= up_d;
      dn_pend_q <= dn_d;
      w_q <= (up_d | dn_d) ? ((w_q == 4'hF) ? w_q : w_q + 4'h1) : 4'h0;
      // one decision per reference period
      unlock_pulse_q <= fref_edge & period_bad;
      if (fref_edge) begin
        locked_q <= ~period_bad;
        bad_q <= 1'b0;
        fp_seen_q <= fp_edge;
      end else begin
        bad_q <= bad_q | too_wide;
        fp_seen_q <= fp_seen_q | fp_edge;
      end
      kick_q <= fref_edge & on_on;
      // on/on pumps both sides every period even when in phase
      pump_up_q <= (up_pend_q & (w_q >= thr)) | kick_q;
      pump_dn_q <= (dn_pend_q & (w_q >= thr)) | kick_q;
    end
  end
endmodule : pls_lock_det

// file: pls_dev_end.sv
// synthesizer end: serial control latch, sticky unlock flag, data-out selection
// Functional notes
// - judge lock once per reference period
// - controller waits two periods after divisor change
// - unlock flag sticks until next transfer
// - controller ignores first readout after divisor change
// - direct lock output high locked, low unlocked
// - two bits pick four dead-zone modes
// - no-dead-zone modes pulse even when locked
// - controller prefers dead zone for modest needs; the controller passes the mode field from software through unchanged
// - data-out may show count done or lock
// - data-out may mirror general input pin
// - controller enables IF only with station detect
// - control data takes effect on enable fall
`timescale 1ns/1ps
module pls_dev_end import pls_pkg::*; #(
  parameter int FBITS = FRAME_BITS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  pls_link_if.device link,
  // synthesizer pins
  input wire logic fref_pin,
  input wire logic fp_pin,
  input wire logic if_done_pin,
  input wire logic in_pin,
  // control outputs
  output logic [DIV_W-1:0] divisor_q,
  output logic dead_zone_sel_hi,
  output logic dead_zone_sel_lo,
  output logic pump_up,
  output logic pump_dn,
  output logic unlock_flag
);
  localparam int NS = 7;
  logic [NS-1:0] s1_q, s2_q, s3_q;
  wire [NS-1:0] raw = {in_pin, if_done_pin, fp_pin, fref_pin, link.di, link.cl, link.ce};
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
        end
      end
    end
  endgenerate
  wire ce = s2_q[0];
  wire ce_rise = s2_q[0] & ~s3_q[0];
  wire ce_fall = ~s2_q[0] & s3_q[0];
  wire cl_rise = s2_q[1] & ~s3_q[1];
  wire di = s2_q[2];
  wire fref_edge = s2_q[3] & ~s3_q[3];
  wire fp_edge = s2_q[4] & ~s3_q[4];
  wire if_done = s2_q[5];
  wire in_lvl = s2_q[6];

  logic [FBITS-1:0] shift_q;
  logic [5:0] cnt_q;
  logic rd_bit_q, unlock_flag_q;
  pls_dz_t dz_q;
  pls_do_t do_sel_q;
  logic do_q;
  logic unlock_pulse, locked, up_w, dn_w;

  pls_lock_det u_det (
    .pclk(pclk),
    .presetn(presetn),
    .fref_edge(fref_edge),
    .fp_edge(fp_edge),
    .dz_mode(dz_q),
    .unlock_pulse_q(unlock_pulse),
    .locked_q(locked),
    .pump_up_q(up_w),
    .pump_dn_q(dn_w)
  );

  // short or long frames are dropped whole rather than half applied
  wire frame_ok = ce_fall && (cnt_q == 6'(FBITS));
  wire pls_do_t do_new = pls_do_t'(shift_q[DO_SEL_POS +: 2]);
  wire pls_dz_t dz_new = pls_dz_t'(shift_q[DZ_POS +: 2]);
  wire do_d = (do_sel_q == do_serial) ? (ce & rd_bit_q) :
              (do_sel_q == do_lock) ? locked :
              (do_sel_q == do_if_done) ? if_done : in_lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= '0;
      cnt_q <= 6'h00;
      rd_bit_q <= 1'b0;
    end else begin
      if (ce_rise) begin
        cnt_q <= 6'h00;
        rd_bit_q <= unlock_flag_q;
      end else if (ce && cl_rise) begin
        shift_q <= {di, shift_q[FBITS-1:1]};
        cnt_q <= (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_q <= '0;
      dz_q <= dz_mode_none_a;
      do_sel_q <= do_serial;
    end else if (frame_ok) begin
      divisor_q <= shift_q[DIV_W-1:0];
      dz_q <= dz_new;
      do_sel_q <= do_new;
    end
  end

  // a fresh unlock in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_flag_q <= 1'b0;
    end else if (unlock_pulse) begin
      unlock_flag_q <= 1'b1;
    end else if (ce_fall) begin
      unlock_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_q <= 1'b0;
      pump_up <= 1'b0;
      pump_dn <= 1'b0;
      dead_zone_sel_hi <= 1'b0;
      dead_zone_sel_lo <= 1'b0;
      unlock_flag <= 1'b0;
    end else begin
      do_q <= do_d;
      pump_up <= up_w;
      pump_dn <= dn_w;
      dead_zone_sel_hi <= dz_q[1];
      dead_zone_sel_lo <= dz_q[0];
      unlock_flag <= unlock_flag_q;
    end
  end
  assign link.do_line = do_q;
endmodule : pls_dev_end

// file: pls_ctl_end.sv
// controller end: apb registers, serial frame master, readout qualification
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module pls_ctl_end import pls_pkg::*; #(
  parameter int HALF = CL_HALF_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  pls_link_if.ctrl link,
  // tuner side
  input wire logic station_detect,
  output logic if_buffer_en,
  output logic irq
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_SETUP = 3'b001, S_LOW = 3'b010, S_HIGH = 3'b011, S_END = 3'b100
  } pls_st_t;
  pls_st_t st_q;
  logic [31:0] ctrl_q, settle_q, settle_cnt_q;
  logic [1:0] irq_stat_q, irq_mask_q, reads_q;
  logic [7:0] tmr_q;
  logic [5:0] bit_q;
  logic [FRAME_BITS-1:0] tx_q;
  logic [DIV_W-1:0] last_div_q;
  logic div_chg_q, unlock_rd_q, valid_q, ce_q, cl_q, di_q, sampled_q;
  logic do1_q, do2_q, stn1_q, stn2_q;

  wire busy = (st_q != S_IDLE);
  wire wr_fire = psel & penable & pready & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire a_ctrl = (paddr == REG_CTRL);
  wire a_stat = (paddr == REG_STATUS);
  wire a_ist = (paddr == REG_IRQ_STAT);
  wire a_imask = (paddr == REG_IRQ_MASK);
  wire a_settle = (paddr == REG_SETTLE);
  wire mapped = a_ctrl | a_stat | a_ist | a_imask | a_settle;
  wire start = wr_fire & a_ctrl & ~busy;
  wire tdone = (tmr_q == 8'(HALF - 1));
  wire frame_end = (st_q == S_END) & tdone;
  wire settled = (settle_cnt_q == 32'h0);
  wire [1:0] reads_nx = (reads_q == 2'(READS_VALID)) ? reads_q : reads_q + 2'h1;
  wire rd_valid_nx = div_chg_q ? 1'b0 : (reads_nx == 2'(READS_VALID));
  wire [31:0] status = {27'h0, do2_q, settled, valid_q, unlock_rd_q, busy};
  wire [31:0] rd_mux = a_ctrl ? ctrl_q : a_stat ? status : a_ist ? {30'h0, irq_stat_q} :
                       a_imask ? {30'h0, irq_mask_q} : a_settle ? settle_q : 32'h0;
  wire [1:0] ev = {frame_end & rd_valid_nx & sampled_q, frame_end};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= rd_setup ? rd_mux : prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      settle_q <= SETTLE_RST;
      irq_mask_q <= 2'h0;
      irq_stat_q <= 2'h0;
    end else begin
      if (start) ctrl_q <= pwdata;
      if (wr_fire & a_settle) settle_q <= pwdata;
      if (wr_fire & a_imask) irq_mask_q <= pwdata[1:0];
      // set wins over write-one-to-clear
      irq_stat_q <= (irq_stat_q & ~((wr_fire & a_ist) ? pwdata[1:0] : 2'h0)) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      tmr_q <= 8'h0;
      bit_q <= 6'h0;
      tx_q <= '0;
      ce_q <= 1'b0;
      cl_q <= 1'b0;
      di_q <= 1'b0;
      sampled_q <= 1'b0;
      unlock_rd_q <= 1'b0;
    end else begin
      tmr_q <= (start | tdone) ? 8'h0 : tmr_q + 8'h1;
      unique case (st_q)
        S_IDLE: if (start) begin
          st_q <= S_SETUP;
          ce_q <= 1'b1;
          tx_q <= pwdata[FRAME_BITS-1:0];
          bit_q <= 6'h0;
          sampled_q <= 1'b0;
        end
        S_SETUP: if (tdone) begin
          st_q <= S_LOW;
          cl_q <= 1'b0;
          di_q <= tx_q[0];
        end
        S_LOW: if (tdone) begin
          st_q <= S_HIGH;
          cl_q <= 1'b1;
        end
        S_HIGH: if (tdone) begin
          if (!sampled_q) begin
            unlock_rd_q <= do2_q;
            sampled_q <= 1'b1;
          end
          cl_q <= 1'b0;
          tx_q <= tx_q >> 1;
          bit_q <= bit_q + 6'h1;
          di_q <= tx_q[1];
          st_q <= (bit_q == 6'(FRAME_BITS - 1)) ? S_END : S_LOW;
          ce_q <= (bit_q == 6'(FRAME_BITS - 1)) ? 1'b0 : 1'b1;
        end
        S_END: if (tdone) st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // the first readout after a divisor change still carries the old flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_div_q <= '0;
      div_chg_q <= 1'b0;
      reads_q <= 2'h0;
      valid_q <= 1'b0;
      settle_cnt_q <= 32'h0;
    end else begin
      if (start) div_chg_q <= (pwdata[DIV_W-1:0] != last_div_q);
      if (frame_end) begin
        last_div_q <= ctrl_q[DIV_W-1:0];
        reads_q <= div_chg_q ? 2'h0 : reads_nx;
        valid_q <= rd_valid_nx;
      end
      // software keeps settle at two or more reference periods
      if (frame_end & div_chg_q) settle_cnt_q <= settle_q;
      else if (!settled) settle_cnt_q <= settle_cnt_q - 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do1_q <= 1'b0;
      do2_q <= 1'b0;
      stn1_q <= 1'b0;
      stn2_q <= 1'b0;
      if_buffer_en <= 1'b0;
      irq <= 1'b0;
    end else begin
      do1_q <= link.do_line;
      do2_q <= do1_q;
      stn1_q <= station_detect;
      stn2_q <= stn1_q;
      if_buffer_en <= ctrl_q[IF_REQ_POS] & stn2_q;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end
  // dead-zone choice is left to software; the mode field goes out unchanged
  assign link.ce = ce_q;
  assign link.cl = cl_q;
  assign link.di = di_q;
endmodule : pls_ctl_end

// file: pls_link_assertions.sv
// protocol and lock-status checker beside the serial link
`timescale 1ns/1ps
module pls_link_assertions import pls_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link and device outputs
  input wire logic ce,
  input wire logic cl,
  input wire logic di,
  input wire logic do_line,
  input wire logic unlock_flag,
  input wire logic dead_zone_sel_hi,
  input wire logic dead_zone_sel_lo,
  input wire logic pump_up,
  input wire logic pump_dn
);
  logic ce_q;
  logic cl_q;
  logic [2:0] fall_q;
  logic [4:0] bits_q;
  wire ce_fall = ce_q & ~ce;
  wire ce_rise = ce & ~ce_q;
  wire cl_rise = cl & ~cl_q;
  // saturates so a long idle never wraps back into the window
  wire [2:0] fall_d = ce_fall ? 3'h0 : ((fall_q == 3'h7) ? fall_q : fall_q + 3'h1);
  wire [4:0] bits_d = ce_rise ? 5'h00 : bits_q + {4'h0, cl_rise};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_q <= 1'b0;
      cl_q <= 1'b0;
      fall_q <= 3'h7;
      bits_q <= 5'h00;
    end else begin
      ce_q <= ce;
      cl_q <= cl;
      fall_q <= fall_d;
      bits_q <= bits_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cl_in_frame: assert property ($rose(cl) |-> ce)
    else $error("serial clock rose outside a frame");
  a_cl_high_width: assert property ($rose(cl) |=> cl [*3] ##1 !cl)
    else $error("serial clock high phase not four cycles");
  a_ce_setup: assert property ($rose(ce) |-> !cl [*4])
    else $error("serial clock moved during frame setup");
  a_ce_end_low: assert property ($fell(ce) |-> !cl)
    else $error("frame ended with serial clock high");
  a_di_hold: assert property ($rose(cl) |=> $stable(di) [*3])
    else $error("data changed while serial clock high");
  a_frame_bits: assert property ($fell(ce) |-> bits_q == FRAME_BITS)
    else $error("frame bit count wrong");
  a_unlock_sticky: assert property ($fell(unlock_flag) |-> fall_q <= 3'h5)
    else $error("unlock flag cleared without a transfer");
  a_dz_latch: assert property ($changed({dead_zone_sel_hi, dead_zone_sel_lo})
    |-> fall_q <= 3'h5)
    else $error("dead zone select changed away from frame end");
  a_dz_pumps: assert property ((pump_up && pump_dn) |-> !(dead_zone_sel_hi
    && $past(dead_zone_sel_hi) && $past(dead_zone_sel_hi, 2)))
    else $error("both pumps on inside a dead zone mode");
  c_do_in_frame: cover property (ce && do_line);
endmodule : pls_link_assertions

// file: tb_top.sv
// bench joining controller end and synthesizer end across the link
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top import pls_pkg::*;;
  localparam logic [31:0] DIV = 32'h0000_1234;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fref_pin = 1'b0;
  logic fp_pin = 1'b0;
  logic fp_en = 1'b1;
  logic fp_gate = 1'b1;
  logic if_done_pin = 1'b0;
  logic in_pin = 1'b0;
  logic station_detect = 1'b0;
  logic [DIV_W-1:0] divisor_q;
  logic dead_zone_sel_hi;
  logic dead_zone_sel_lo;
  logic pump_up;
  logic pump_dn;
  logic unlock_flag;
  logic if_buffer_en;
  logic irq;
  logic [31:0] rd;
  logic err;
  logic [5:0] fcnt = 6'h00;
  int mismatches = 0;
  int cmp_count = 0;
  pls_link_if i_pls_link_if ();
  pls_dev_end i_pls_dev_end (.pclk(pclk), .presetn(presetn), .link(i_pls_link_if.device),
    .fref_pin(fref_pin), .fp_pin(fp_pin), .if_done_pin(if_done_pin), .in_pin(in_pin),
    .divisor_q(divisor_q), .dead_zone_sel_hi(dead_zone_sel_hi),
    .dead_zone_sel_lo(dead_zone_sel_lo), .pump_up(pump_up), .pump_dn(pump_dn),
    .unlock_flag(unlock_flag));
  pls_ctl_end i_pls_ctl_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(i_pls_link_if.ctrl), .station_detect(station_detect),
    .if_buffer_en(if_buffer_en), .irq(irq));
  pls_link_assertions i_pls_link_assertions (.pclk(pclk), .presetn(presetn),
    .ce(i_pls_link_if.ce), .cl(i_pls_link_if.cl), .di(i_pls_link_if.di),
    .do_line(i_pls_link_if.do_line), .unlock_flag(unlock_flag),
    .dead_zone_sel_hi(dead_zone_sel_hi), .dead_zone_sel_lo(dead_zone_sel_lo),
    .pump_up(pump_up), .pump_dn(pump_dn));
  always #50 pclk = ~pclk;
  // reference every 40 cycles; divided edge lags one cycle, inside the lock window
  // enable switches only while reference is low, so no divided edge lands mid-period
  always @(posedge pclk) begin
    fcnt <= (fcnt == 6'h27) ? 6'h00 : fcnt + 6'h01;
    fref_pin <= (fcnt < 6'h14);
    if (fcnt == 6'h27) fp_gate <= fp_en;
    fp_pin <= fp_gate & fref_pin;
  end
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // busy may lag the write, so polling starts a little later
  task automatic frame(input logic [31:0] v);
    int n;
    apb(1'b1, REG_CTRL, v);
    cyc(2);
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 100);
    if (rd[ST_BUSY] !== 1'b0) begin
      mismatches++;
      wrap_up();
    end
  endtask : frame
  task automatic t_reset();
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    `CHK("ctrl", CTRL_RST, rd)
    apb(1'b0, REG_SETTLE, 32'h0000_0000);
    `CHK("settle", SETTLE_RST, rd)
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0000_0000, rd)
    apb(1'b1, REG_SETTLE, 32'h0000_0050);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_lock();
    frame(DIV);
    `CHK("settling", 1'b0, rd[ST_SETTLED])
    cyc(120);
    `CHK("divisor", DIV[15:0], divisor_q)
    `CHK("flag locked", 1'b0, unlock_flag)
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    `CHK("settled", 1'b1, rd[ST_SETTLED])
    fp_en <= 1'b0;
    cyc(120);
    `CHK("flag set", 1'b1, unlock_flag)
    fp_en <= 1'b1;
    cyc(120);
    `CHK("flag held", 1'b1, unlock_flag)
    frame(DIV);
    `CHK("read unlock", 1'b1, rd[ST_UNLOCK])
    `CHK("read invalid", 1'b0, rd[ST_VALID])
    `CHK("flag cleared", 1'b0, unlock_flag)
    frame(DIV);
    `CHK("read lock", 1'b0, rd[ST_UNLOCK])
    `CHK("read valid", 1'b1, rd[ST_VALID])
    $display("t_lock done");
  endtask : t_lock
  task automatic t_do();
    frame(DIV | 32'h0004_0000);
    cyc(80);
    `CHK("do locked", 1'b1, i_pls_link_if.do_line)
    fp_en <= 1'b0;
    cyc(100);
    `CHK("do unlocked", 1'b0, i_pls_link_if.do_line)
    fp_en <= 1'b1;
    cyc(160);
    `CHK("do relocked", 1'b1, i_pls_link_if.do_line)
    frame(DIV | 32'h0008_0000);
    if_done_pin <= 1'b1;
    cyc(5);
    `CHK("do if done", 1'b1, i_pls_link_if.do_line)
    if_done_pin <= 1'b0;
    cyc(5);
    `CHK("do if idle", 1'b0, i_pls_link_if.do_line)
    frame(DIV | 32'h000C_0000);
    in_pin <= 1'b1;
    cyc(5);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    `CHK("status do", 1'b1, rd[ST_DO])
    in_pin <= 1'b0;
    cyc(5);
    `CHK("do pin low", 1'b0, i_pls_link_if.do_line)
    $display("t_do done");
  endtask : t_do
  task automatic t_dz();
    int n;
    int k;
    station_detect <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      frame(DIV | 32'h0010_0000 | (m << DZ_POS));
      `CHK("dz sel", 2'(m), {dead_zone_sel_hi, dead_zone_sel_lo})
      n = 0;
      k = 0;
      repeat (80) begin
        @(posedge pclk);
        if (pump_up === 1'b1) n++;
        if (pump_dn === 1'b1) k++;
      end
      if (m < 2) `CHK("pulses on", 1'b1, n > 0)
      if (m < 2) `CHK("dn pulses on", 1'b1, k > 0)
      if (m == 2) `CHK("pulses narrow", 1'b1, n > 0)
      if (m == 3) `CHK("pulses wide", 1'b1, n == 0)
      if (m == 3) `CHK("dn pulses wide", 1'b1, k == 0)
    end
    `CHK("if buffer", 1'b1, if_buffer_en)
    $display("t_dz done");
  endtask : t_dz
  task automatic t_irq();
    apb(1'b1, REG_IRQ_STAT, 32'h0000_0003);
    apb(1'b1, REG_IRQ_MASK, 32'h0000_0001);
    cyc(2);
    `CHK("irq idle", 1'b0, irq)
    frame(DIV);
    cyc(2);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, REG_IRQ_STAT, 32'h0000_0001);
    cyc(2);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b0, REG_IRQ_STAT, 32'h0000_0000);
    `CHK("done bit", 1'b0, rd[IRQ_DONE])
    `CHK("valid bit", 1'b1, rd[IRQ_UNLOCK])
    $display("t_irq done");
  endtask : t_irq
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_lock();
    t_do();
    t_dz();
    t_irq();
    wrap_up();
  end
endmodule : tb_top
